// ### rtl/pull_cfg_regs.svh
// register offsets, reset values and field positions of the pad pull and
// high-speed exit delay bank; included by the package and the design files
`ifndef PULL_CFG_REGS_SVH
`define PULL_CFG_REGS_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define CFG_ADDR_W 8
`define CFG_DATA_W 16

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define HS_EXIT_DELAY_OFS 8'hdf
`define STRAP_PULL_OFS 8'he0
`define VIDEO_PULL_OFS 8'he1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define HS_EXIT_DELAY_RST 6'h10
`define STRAP_PULL_RST 16'h5556
`define VIDEO_PULL_RST 16'h6656

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define HS_EXIT_DELAY_W 6
`define HS_EXIT_RSVD_W 10
`define PULL_SEL_W 2
`define PULL_FIELDS 8
// lsb of each pull selector in the strap register
`define XTAL_PULL_LSB 14
`define STRAP4_PULL_LSB 12
`define STRAP3_PULL_LSB 10
`define STRAP2_PULL_LSB 8
`define STRAP1_PULL_LSB 6
`define STRAP0_PULL_LSB 4
`define HOST_SEL_PULL_LSB 2
`define LINK_RST_PULL_LSB 0
// lsb of each pull selector in the video register
`define DEN_PULL_LSB 14
`define HSYNC_PULL_LSB 12
`define PCLK_PULL_LSB 10
`define VSYNC_PULL_LSB 8
`define PIX_HIGH_PULL_LSB 6
`define PIX_MID_PULL_LSB 4
`define PIX_LOW_PULL_LSB 2
`define CHIP_SEL_PULL_LSB 0

`endif

// ### rtl/pull_cfg_pkg.sv
// types shared by the pull configuration bank and its pad decoder
// assumes pull_cfg_regs.svh is on the include path
package pull_cfg_pkg;

`include "pull_cfg_regs.svh"

  // selector encodings, one per pad
  typedef enum logic [1:0] {
    PULL_NONE = 2'b00,
    PULL_DOWN = 2'b01,
    PULL_UP = 2'b10,
    PULL_KEEP = 2'b11
  } pull_mode_t;

  // pad control lines of one pin or pin group
  typedef struct packed {
    logic up;
    logic down;
    logic keep;
  } pad_pull_t;

  // one register bus request
  typedef struct packed {
    logic [`CFG_ADDR_W-1:0] addr;
    logic [`CFG_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // register state of the bank; the pad lines are held in pull_decode
  typedef struct packed {
    logic [`HS_EXIT_DELAY_W-1:0] delay;
    logic [`CFG_DATA_W-1:0] strap;
    logic [`CFG_DATA_W-1:0] video;
    logic [`CFG_DATA_W-1:0] rdata;
  } cfg_state_t;

endpackage

// ### rtl/pull_decode.sv
// registered decoder from one two-bit pull selector to pad control lines
// assumes sel is the selector's next value, so the pad lines change on
// the same edge as the register that holds the selector
`timescale 1ns/1ps

module pull_decode
#(
  parameter pull_cfg_pkg::pull_mode_t RST_MODE = pull_cfg_pkg::PULL_NONE
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // selector
  input wire logic [1:0] sel,
  // pad controls
  output pull_cfg_pkg::pad_pull_t pad
);

  typedef struct packed {
    pull_cfg_pkg::pad_pull_t pad;
  } dec_state_t;

  dec_state_t state_r;
  dec_state_t state_nxt;

  function automatic pull_cfg_pkg::pad_pull_t decode(input logic [1:0] s);
    pull_cfg_pkg::pad_pull_t p;
    p = '0;
    case (s)
      pull_cfg_pkg::PULL_UP: p.up = 1'b1;
      pull_cfg_pkg::PULL_DOWN: p.down = 1'b1;
      pull_cfg_pkg::PULL_KEEP: p.keep = 1'b1;
      default: p = '0;
    endcase
    return p;
  endfunction

  always_comb
  begin
    state_nxt.pad = decode(sel);
    if (rst)
    begin
      state_nxt.pad = decode(RST_MODE);
    end
  end

  always_ff @(posedge mclk)
  begin
    state_r <= state_nxt;
  end

  assign pad = state_r.pad;

  AST_PAD_EXCLUSIVE: assert property (@(posedge mclk) disable iff (rst)
    $countones({pad.up, pad.down, pad.keep}) <= 1)
    else $error("more than one pad pull line active");

endmodule

// ### rtl/pull_cfg_bank.sv
// pad pull selectors and high-speed exit delay register bank
// assumes a single-cycle register port on mclk, strobes never together
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps

`include "pull_cfg_regs.svh"

module pull_cfg_bank
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire pull_cfg_pkg::reg_req_t req,
  output logic [`CFG_DATA_W-1:0] rd_data,
  // lane controller
  output logic [`HS_EXIT_DELAY_W-1:0] hs_exit_delay,
  // pad controls: strap group 7 xtal, 6..2 strap4..0, 1 host sel, 0 reset
  output pull_cfg_pkg::pad_pull_t [`PULL_FIELDS-1:0] strap_pad,
  // pad controls: video group 7 den, 6 hsync, 5 pclk, 4 vsync,
  // 3 pixel high, 2 pixel mid, 1 pixel low, 0 chip select
  output pull_cfg_pkg::pad_pull_t [`PULL_FIELDS-1:0] video_pad
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  pull_cfg_pkg::cfg_state_t state_r;
  pull_cfg_pkg::cfg_state_t state_nxt;

  logic wr_dly;
  logic wr_strap;
  logic wr_video;
  logic rd_dly;
  logic rd_strap;
  logic rd_video;
  logic rd_unmapped;

  // selector next values, one per pin or pin group
  logic [1:0] strap_sel [`PULL_FIELDS];
  logic [1:0] video_sel [`PULL_FIELDS];

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    wr_dly = 1'b0;
    wr_strap = 1'b0;
    wr_video = 1'b0;
    rd_dly = 1'b0;
    rd_strap = 1'b0;
    rd_video = 1'b0;
    rd_unmapped = 1'b0;
    if (req.addr == `HS_EXIT_DELAY_OFS)
    begin
      wr_dly = req.wr;
      rd_dly = req.rd;
    end
    else if (req.addr == `STRAP_PULL_OFS)
    begin
      wr_strap = req.wr;
      rd_strap = req.rd;
    end
    else if (req.addr == `VIDEO_PULL_OFS)
    begin
      wr_video = req.wr;
      rd_video = req.rd;
    end
    else
    begin
      rd_unmapped = req.rd;
    end
  end

  // ----------------------------------------------------------------------
  // register update and read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    // read data stand for one cycle only
    state_nxt.rdata = '0;
    if (wr_dly)
    begin
      // upper bits are dropped so they always read back as zero
      state_nxt.delay = req.wdata[`HS_EXIT_DELAY_W-1:0];
    end
    if (wr_strap)
    begin
      state_nxt.strap = req.wdata;
    end
    if (wr_video)
    begin
      state_nxt.video = req.wdata;
    end
    if (rd_dly)
    begin
      state_nxt.rdata = {{`HS_EXIT_RSVD_W{1'b0}}, state_r.delay};
    end
    else if (rd_strap)
    begin
      state_nxt.rdata = state_r.strap;
    end
    else if (rd_video)
    begin
      state_nxt.rdata = state_r.video;
    end
    if (rst)
    begin
      state_nxt.delay = `HS_EXIT_DELAY_RST;
      state_nxt.strap = `STRAP_PULL_RST;
      state_nxt.video = `VIDEO_PULL_RST;
      state_nxt.rdata = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    state_r <= state_nxt;
  end

  assign rd_data = state_r.rdata;
  assign hs_exit_delay = state_r.delay;

  // ----------------------------------------------------------------------
  // selector field map
  // ----------------------------------------------------------------------
  // decoders take next values so pads switch on the write's own edge
  always_comb
  begin
    strap_sel[7] = state_nxt.strap[`XTAL_PULL_LSB+:2];
    strap_sel[6] = state_nxt.strap[`STRAP4_PULL_LSB+:2];
    strap_sel[5] = state_nxt.strap[`STRAP3_PULL_LSB+:2];
    strap_sel[4] = state_nxt.strap[`STRAP2_PULL_LSB+:2];
    strap_sel[3] = state_nxt.strap[`STRAP1_PULL_LSB+:2];
    strap_sel[2] = state_nxt.strap[`STRAP0_PULL_LSB+:2];
    strap_sel[1] = state_nxt.strap[`HOST_SEL_PULL_LSB+:2];
    strap_sel[0] = state_nxt.strap[`LINK_RST_PULL_LSB+:2];
    video_sel[7] = state_nxt.video[`DEN_PULL_LSB+:2];
    video_sel[6] = state_nxt.video[`HSYNC_PULL_LSB+:2];
    video_sel[5] = state_nxt.video[`PCLK_PULL_LSB+:2];
    video_sel[4] = state_nxt.video[`VSYNC_PULL_LSB+:2];
    video_sel[3] = state_nxt.video[`PIX_HIGH_PULL_LSB+:2];
    video_sel[2] = state_nxt.video[`PIX_MID_PULL_LSB+:2];
    video_sel[1] = state_nxt.video[`PIX_LOW_PULL_LSB+:2];
    video_sel[0] = state_nxt.video[`CHIP_SEL_PULL_LSB+:2];
  end

  // ----------------------------------------------------------------------
  // pad decoders
  // ----------------------------------------------------------------------
  localparam logic [`CFG_DATA_W-1:0] STRAP_RST = `STRAP_PULL_RST;
  localparam logic [`CFG_DATA_W-1:0] VIDEO_RST = `VIDEO_PULL_RST;

  genvar gi;
  generate
    for (gi = 0; gi < `PULL_FIELDS; gi = gi + 1)
    begin : g_pad
      pull_decode
      #(
        .RST_MODE(pull_cfg_pkg::pull_mode_t'(STRAP_RST[2*gi+:2]))
      )
      u_strap
      (
        .mclk(mclk),
        .rst(rst),
        .sel(strap_sel[gi]),
        .pad(strap_pad[gi])
      );
      pull_decode
      #(
        .RST_MODE(pull_cfg_pkg::pull_mode_t'(VIDEO_RST[2*gi+:2]))
      )
      u_video
      (
        .mclk(mclk),
        .rst(rst),
        .sel(video_sel[gi]),
        .pad(video_pad[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_dly_write;
    wr_dly;
  endsequence

  sequence s_strap_write_read;
    wr_strap ##1 rd_strap;
  endsequence

  sequence s_video_write_read;
    wr_video ##1 rd_video;
  endsequence

  sequence s_dly_dirty_write_read;
    (wr_dly && req.wdata[`CFG_DATA_W-1:`HS_EXIT_DELAY_W] != '0) ##1 rd_dly;
  endsequence

  property p_pad(logic w, logic [1:0] s, pull_cfg_pkg::pad_pull_t p);
    w |=> p.up == ($past(s) == 2'b10) && p.down == ($past(s) == 2'b01)
      && p.keep == ($past(s) == 2'b11);
  endproperty

  AST_DLY_WRITE: assert property (
    s_dly_write |=> hs_exit_delay == $past(req.wdata[5:0]))
    else $error("exit delay did not take the written value");

  // a reset reloads the bank, so its cycle is never a hold cycle
  AST_DLY_HOLD: assert property (
    !rst && !wr_dly |=> $stable(hs_exit_delay))
    else $error("exit delay changed without a write");

  AST_RESET_VAL: assert property (
    disable iff (1'b0) rst |=> hs_exit_delay == `HS_EXIT_DELAY_RST
      && state_r.strap == STRAP_RST && state_r.video == VIDEO_RST)
    else $error("wrong value after reset");

  AST_DLY_READ: assert property (
    rd_dly |=> rd_data == {10'h000, hs_exit_delay})
    else $error("delay read back wrong or reserved bits set");

  AST_RSVD_IGNORED: assert property (
    s_dly_dirty_write_read |=> rd_data[15:6] == 10'h000
      && rd_data[5:0] == $past(req.wdata[5:0], 2))
    else $error("reserved bits of delay register were stored");

  AST_STRAP_READBACK: assert property (
    s_strap_write_read |=> rd_data == $past(req.wdata, 2))
    else $error("strap pull register read back wrong");

  AST_VIDEO_READBACK: assert property (
    s_video_write_read |=> rd_data == $past(req.wdata, 2))
    else $error("video pull register read back wrong");

  AST_RDATA_IDLE: assert property (
    !req.rd |=> rd_data == 16'h0000)
    else $error("read data present without a read");

  AST_UNMAPPED: assert property (
    rd_unmapped |=> rd_data == 16'h0000)
    else $error("unmapped read returned data");

  AST_XTAL_PAD: assert property (
    p_pad(wr_strap, req.wdata[15:14], strap_pad[7]))
    else $error("crystal-mode pad pull wrong");

  AST_STRAP4_PAD: assert property (
    p_pad(wr_strap, req.wdata[13:12], strap_pad[6]))
    else $error("strap four pad pull wrong");

  AST_STRAP0_PAD: assert property (
    p_pad(wr_strap, req.wdata[5:4], strap_pad[2]))
    else $error("strap zero pad pull wrong");

  AST_HOST_SEL_PAD: assert property (
    p_pad(wr_strap, req.wdata[3:2], strap_pad[1]))
    else $error("host-select pad pull wrong");

  AST_LINK_RST_PAD: assert property (
    p_pad(wr_strap, req.wdata[1:0], strap_pad[0]))
    else $error("link reset pad pull wrong");

  AST_DEN_PAD: assert property (
    p_pad(wr_video, req.wdata[15:14], video_pad[7]))
    else $error("data-enable pad pull wrong");

  AST_PCLK_PAD: assert property (
    p_pad(wr_video, req.wdata[11:10], video_pad[5]))
    else $error("pixel clock pad pull wrong");

  AST_VSYNC_PAD: assert property (
    p_pad(wr_video, req.wdata[9:8], video_pad[4]))
    else $error("vsync pad pull wrong");

  AST_PIX_LOW_PAD: assert property (
    p_pad(wr_video, req.wdata[3:2], video_pad[1]))
    else $error("pixel low byte pad pull wrong");

  AST_CHIP_SEL_PAD: assert property (
    p_pad(wr_video, req.wdata[1:0], video_pad[0]))
    else $error("chip-select pad pull wrong");

  AST_STRAP3_PAD: assert property (
    p_pad(wr_strap, req.wdata[`STRAP3_PULL_LSB+:2], strap_pad[5]))
    else $error("strap three pad pull wrong");

  AST_STRAP2_PAD: assert property (
    p_pad(wr_strap, req.wdata[`STRAP2_PULL_LSB+:2], strap_pad[4]))
    else $error("strap two pad pull wrong");

  AST_STRAP1_PAD: assert property (
    p_pad(wr_strap, req.wdata[`STRAP1_PULL_LSB+:2], strap_pad[3]))
    else $error("strap one pad pull wrong");

  AST_HSYNC_PAD: assert property (
    p_pad(wr_video, req.wdata[`HSYNC_PULL_LSB+:2], video_pad[6]))
    else $error("hsync pad pull wrong");

  AST_PIX_HIGH_PAD: assert property (
    p_pad(wr_video, req.wdata[`PIX_HIGH_PULL_LSB+:2], video_pad[3]))
    else $error("pixel high byte pad pull wrong");

  AST_PIX_MID_PAD: assert property (
    p_pad(wr_video, req.wdata[`PIX_MID_PULL_LSB+:2], video_pad[2]))
    else $error("pixel mid byte pad pull wrong");

  AST_STRAP_READ: assert property (
    rd_strap |=> rd_data == $past(state_r.strap))
    else $error("strap pull register read wrong");

  AST_VIDEO_READ: assert property (
    rd_video |=> rd_data == $past(state_r.video))
    else $error("video pull register read wrong");

  // pads must leave reset already pulled, before software writes anything
  AST_RESET_LINK_PAD: assert property (
    disable iff (1'b0) p_pad(rst, STRAP_RST[`LINK_RST_PULL_LSB+:2],
      strap_pad[0]))
    else $error("link reset pad pull wrong after reset");

  AST_RESET_CHIP_SEL_PAD: assert property (
    disable iff (1'b0) p_pad(rst, VIDEO_RST[`CHIP_SEL_PULL_LSB+:2],
      video_pad[0]))
    else $error("chip-select pad pull wrong after reset");

  AST_PADS_HOLD: assert property (
    !rst && !wr_strap && !wr_video
      |=> $stable(strap_pad) && $stable(video_pad))
    else $error("pad controls changed without a write");

endmodule

// ### dv/pull_cfg_bank_test.sv
// self-checking bench for the pad pull and exit delay register bank
// assumes the register port of pull_cfg_bank and pull_cfg_regs.svh
`timescale 1ns/1ps

`include "pull_cfg_regs.svh"

module pull_cfg_bank_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pull_cfg_pkg::reg_req_t req = '0;
  pull_cfg_pkg::reg_req_t prev = '0;
  logic [15:0] rd_data;
  logic [5:0] hs_exit_delay;
  pull_cfg_pkg::pad_pull_t [7:0] strap_pad;
  pull_cfg_pkg::pad_pull_t [7:0] video_pad;
  logic [5:0] delay_m;
  logic [15:0] strap_m;
  logic [15:0] video_m;
  logic [31:0] seed = 32'h3865a26d;
  int err_count = 0;
  int compares = 0;

  always #12.5 mclk = ~mclk;

  pull_cfg_bank pull_cfg_bank_i
  (
    .mclk(mclk),
    .rst(rst),
    .req(req),
    .rd_data(rd_data),
    .hs_exit_delay(hs_exit_delay),
    .strap_pad(strap_pad),
    .video_pad(video_pad)
  );

  // ----------------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic pull_cfg_pkg::pad_pull_t dec(input logic [1:0] s);
    dec = '0;
    dec.up = (s == 2'b10);
    dec.down = (s == 2'b01);
    dec.keep = (s == 2'b11);
  endfunction

  // unmapped places read as zero
  function automatic logic [15:0] rdm(input logic [7:0] a);
    case (a)
      8'hdf: rdm = {10'h000, delay_m};
      8'he0: rdm = strap_m;
      8'he1: rdm = video_m;
      default: rdm = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // compares every output against the model once the previous request
  // has been taken, so back-to-back traffic is checked at every result
  task automatic check_all;
    int i;
    logic [15:0] sp;
    logic [15:0] vp;
    if (prev.wr)
    begin
      case (prev.addr)
        8'hdf: delay_m = prev.wdata[5:0];
        8'he0: strap_m = prev.wdata;
        8'he1: video_m = prev.wdata;
        default: ;
      endcase
    end
    chk("rd_data", rd_data, prev.rd ? rdm(prev.addr) : 16'h0000);
    chk("hs_exit_delay", 16'(hs_exit_delay), 16'(delay_m));
    for (i = 0; i < 8; i++)
    begin
      sp = 16'(dec(strap_m[2*i +: 2]));
      vp = 16'(dec(video_m[2*i +: 2]));
      chk("strap", 16'(strap_pad[i]), sp);
      chk("video", 16'(video_pad[i]), vp);
    end
  endtask

  // ----------------------------------------------------------------------
  // register port driver
  // ----------------------------------------------------------------------
  task automatic op(input logic wr, input logic rd, input logic [7:0] a,
                    input logic [15:0] d);
    @(posedge mclk);
    req <= {a, d, wr, rd};
    @(negedge mclk);
    check_all;
    prev = {a, d, wr, rd};
  endtask

  task automatic do_reset(input int n);
    @(posedge mclk);
    rst <= 1'b1;
    req <= '0;
    repeat (n - 1) @(posedge mclk);
    rst <= 1'b0;
    delay_m = `HS_EXIT_DELAY_RST;
    strap_m = `STRAP_PULL_RST;
    video_m = `VIDEO_PULL_RST;
    prev = '0;
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    int c;
    int k;
    do_reset(4);
    op(1'b0, 1'b0, 8'h00, 16'h0000);
    op(1'b0, 1'b1, 8'hdf, 16'h0000);
    op(1'b0, 1'b1, 8'he0, 16'h0000);
    op(1'b0, 1'b1, 8'he1, 16'h0000);
    op(1'b0, 1'b0, 8'h00, 16'h0000);
    $display("test reset_values done");
    // every selector code in every field, read back after both registers are written
    for (c = 0; c < 4; c++)
    begin
      op(1'b1, 1'b0, 8'he0, {8{c[1:0]}});
      op(1'b1, 1'b0, 8'he1, {8{c[1:0]}});
      op(1'b0, 1'b1, 8'he0, 16'h0000);
      op(1'b0, 1'b1, 8'he1, 16'h0000);
    end
    // distinct codes per field catch swapped field positions
    op(1'b1, 1'b0, 8'he0, 16'h1b4e);
    op(1'b0, 1'b1, 8'he0, 16'h0000);
    op(1'b1, 1'b0, 8'he1, 16'he4b1);
    op(1'b0, 1'b1, 8'he1, 16'h0000);
    $display("test pull_codes done");
    // reserved delay bits are dropped and read zero
    op(1'b1, 1'b0, 8'hdf, 16'hffff);
    op(1'b0, 1'b1, 8'hdf, 16'h0000);
    op(1'b1, 1'b0, 8'hdf, 16'hffc0);
    op(1'b0, 1'b1, 8'hdf, 16'h0000);
    $display("test delay_field done");
    // unmapped neighbours must not alias onto the bank
    op(1'b1, 1'b0, 8'hde, 16'hffff);
    op(1'b1, 1'b0, 8'he2, 16'hffff);
    op(1'b0, 1'b1, 8'hde, 16'h0000);
    op(1'b0, 1'b1, 8'he2, 16'h0000);
    op(1'b0, 1'b1, 8'he0, 16'h0000);
    $display("test unmapped done");
    for (k = 0; k < 400; k++)
    begin
      seed = xs(seed);
      op(seed[0], ~seed[0] & seed[1],
         seed[3:2] == 2'd0 ? 8'hdf : seed[3:2] == 2'd1 ? 8'he0 :
         seed[3:2] == 2'd2 ? 8'he1 : seed[15:8], seed[31:16]);
    end
    op(1'b0, 1'b0, 8'h00, 16'h0000);
    $display("test random_traffic done");
    // reset in mid-run with a write in flight
    op(1'b1, 1'b0, 8'he0, 16'h0000);
    op(1'b1, 1'b0, 8'hdf, 16'h0003);
    do_reset(2);
    op(1'b0, 1'b1, 8'he0, 16'h0000);
    op(1'b0, 1'b1, 8'hdf, 16'h0000);
    op(1'b0, 1'b0, 8'h00, 16'h0000);
    $display("test mid_reset done");
    test_done;
  end

  // the run needs well under 1000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("FAIL watchdog expected done seen hang");
    test_done;
  end
endmodule
